// >>> hw/sps_status.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: read-only byte gives channel count
// R2: bit0 set when enabled status input active
// R3: bit1 set on faulty or open encoder
// R4: bit2 set when position above upper limit
// R5: bit3 set when position below lower limit
// R6: bit4 set when parameter set rejected
// R7: poll encoder cyclically, bit7 clear
// R8: stop or parameter fault halts polling, bit7
// R9: bit8 high while position equals compare one
// R10: bit9 latches on match, cleared by control
// R11: host clears bit9 via control bit 9
// R12: bit10 set while position at/above compare
// R13: flags update per capture, bits 5-6 zero
module sps_status #(
  parameter int POS_W = sps_pkg::POS_W,
  parameter int N_STS = sps_pkg::N_STS,
  parameter int ADDR_W = sps_pkg::ADDR_W,
  parameter logic [7:0] CHANNELS = sps_pkg::CHANNELS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // encoder link
  input wire logic link_clk,
  input wire logic enc_data,
  output logic enc_clk,
  // encoder status pins
  input wire logic [N_STS-1:0] encoder_status_input,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  typedef struct packed {
    logic tog_seen;
    logic [31:0] pos;
    logic [15:0] diag;
    logic stop;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] cmp1;
    logic [N_STS-1:0] sts_en;
    logic poll_en;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-3:0] wr_idx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sps_core_t;

  sps_core_t s;
  sps_core_t next_s;
  sps_link_if #(.POS_W(POS_W)) lnk ();
  logic [1:0] lnk_q;
  logic tog_sync;
  logic fault_sync;
  logic [N_STS-1:0] sts_sync;
  logic [31:0] new_pos;
  logic param_fault;
  logic cap;
  logic clr1;

  // encoder side runs on the link clock
  sps_link #(.POS_W(POS_W)) u_link (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .enc_data(enc_data),
    .enc_clk(enc_clk),
    .lnk(lnk)
  );

  // frame toggle and fault level into the core domain
  sps_sync #(.WIDTH(2)) u_lnk_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d({lnk.pos_toggle, lnk.link_fault}),
    .q(lnk_q)
  );

  // status pins are asynchronous
  sps_sync #(.WIDTH(N_STS)) u_sts_sync (
    .clk(ref_clk),
    .rst_b(rst_b),
    .d(encoder_status_input),
    .q(sts_sync)
  );

  // helper terms
  assign tog_sync = lnk_q[1];
  assign fault_sync = lnk_q[0];
  assign cap = tog_sync != s.tog_seen; // word is stable once toggle seen
  assign new_pos = 32'(lnk.pos_word);
  assign param_fault = s.lower > s.upper; // limits crossed: unusable set
  assign lnk.poll_en = s.poll_en;

  // merge write data under byte strobes
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction

  // true for any index that decodes to a register
  function automatic logic mapped(input logic [ADDR_W-3:0] idx);
    logic [7:0] i8;
    i8 = 8'(idx);
    return (i8 >= sps_pkg::IDX_CHAN) && (i8 <= sps_pkg::IDX_POS);
  endfunction

  // read data mux
  function automatic logic [31:0] rd_mux(
    input logic [ADDR_W-3:0] idx,
    input sps_core_t c
  );
    logic [31:0] r;
    r = '0;
    case (8'(idx))
      sps_pkg::IDX_CHAN: r = 32'(CHANNELS); // [R1]
      sps_pkg::IDX_DIAG: r = 32'(c.diag);
      sps_pkg::IDX_CTRL: r[sps_pkg::CT_STOP] = c.stop;
      sps_pkg::IDX_UPPER: r = c.upper;
      sps_pkg::IDX_LOWER: r = c.lower;
      sps_pkg::IDX_CMP1: r = c.cmp1;
      sps_pkg::IDX_STS_EN: r = 32'(c.sts_en);
      sps_pkg::IDX_POS: r = c.pos;
      default: r = '0;
    endcase
    return r;
  endfunction

  // next state of the whole core
  always_comb begin
    next_s = s;
    clr1 = 1'b0;

    // write address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.wr_idx = s_axi_awaddr[ADDR_W-1:2];
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end

    // perform the write once both halves are held
    if (next_s.aw_got && next_s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = sps_pkg::RESP_OKAY;
      case (8'(next_s.wr_idx))
        sps_pkg::IDX_CTRL: begin
          if (next_s.wstrb[0]) begin
            next_s.stop = next_s.wdata[sps_pkg::CT_STOP];
          end
          clr1 = next_s.wstrb[1] && next_s.wdata[sps_pkg::CT_CLR1]; // [R11]
        end
        sps_pkg::IDX_UPPER: begin
          next_s.upper = merge(s.upper, next_s.wdata, next_s.wstrb);
        end
        sps_pkg::IDX_LOWER: begin
          next_s.lower = merge(s.lower, next_s.wdata, next_s.wstrb);
        end
        sps_pkg::IDX_CMP1: begin
          next_s.cmp1 = merge(s.cmp1, next_s.wdata, next_s.wstrb);
        end
        sps_pkg::IDX_STS_EN: begin
          next_s.sts_en = N_STS'(merge(32'(s.sts_en), next_s.wdata, next_s.wstrb));
        end
        default: begin
          if (!mapped(next_s.wr_idx)) begin
            next_s.bresp = sps_pkg::RESP_SLVERR;
          end
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // read channel, one read at a time
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd_mux(s_axi_araddr[ADDR_W-1:2], s);
      if (mapped(s_axi_araddr[ADDR_W-1:2])) begin
        next_s.rresp = sps_pkg::RESP_OKAY;
      end else begin
        next_s.rresp = sps_pkg::RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;

    // polling runs unless stopped or parameters rejected
    next_s.poll_en = !(s.stop || param_fault); // [R7] [R8]
    next_s.diag[sps_pkg::DG_SUSP] = s.stop || param_fault; // [R8]
    next_s.diag[sps_pkg::DG_GROUP] = |(sts_sync & s.sts_en); // [R2]
    next_s.diag[sps_pkg::DG_LINK] = fault_sync; // [R3]
    next_s.diag[sps_pkg::DG_PARAM] = param_fault; // [R6]

    // limit and compare flags per captured position
    if (cap) begin
      next_s.tog_seen = tog_sync;
      next_s.pos = new_pos;
      next_s.diag[sps_pkg::DG_UPPER] = new_pos > s.upper; // [R4] [R13]
      next_s.diag[sps_pkg::DG_LOWER] = new_pos < s.lower; // [R5] [R13]
      next_s.diag[sps_pkg::DG_EQ1] = new_pos == s.cmp1; // [R9] [R13]
      next_s.diag[sps_pkg::DG_GE1] = new_pos >= s.cmp1; // [R12] [R13]
    end

    // sticky match flag, a match beats a clear
    next_s.diag[sps_pkg::DG_FLAG1] = (s.diag[sps_pkg::DG_FLAG1] && !clr1)
      || (cap && (new_pos == s.cmp1)); // [R10]

    // reserved and unused bits stay zero
    next_s.diag[6:5] = 2'h0; // [R13]
    next_s.diag[15:11] = 5'h00;

    // synchronous reset
    if (!rst_b) begin
      next_s = '0;
      next_s.upper = sps_pkg::RST_UPPER;
      next_s.lower = sps_pkg::RST_LOWER;
      next_s.cmp1 = sps_pkg::RST_CMP1;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
      next_s.arready = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // bus outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
endmodule // sps_status
`default_nettype wire

// >>> hw/sps_pkg.sv
package sps_pkg;
  // default sizes
  localparam int POS_W = 25;
  localparam int N_STS = 4;
  localparam int ADDR_W = 10;
  localparam logic [7:0] CHANNELS = 8'h01;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CHAN = 8'h6F;
  localparam logic [7:0] IDX_DIAG = 8'h70;
  localparam logic [7:0] IDX_CTRL = 8'h71;
  localparam logic [7:0] IDX_UPPER = 8'h72;
  localparam logic [7:0] IDX_LOWER = 8'h73;
  localparam logic [7:0] IDX_CMP1 = 8'h74;
  localparam logic [7:0] IDX_STS_EN = 8'h75;
  localparam logic [7:0] IDX_POS = 8'h76;
  // diagnostics word bit positions
  localparam int DG_GROUP = 0;
  localparam int DG_LINK = 1;
  localparam int DG_UPPER = 2;
  localparam int DG_LOWER = 3;
  localparam int DG_PARAM = 4;
  localparam int DG_SUSP = 7;
  localparam int DG_EQ1 = 8;
  localparam int DG_FLAG1 = 9;
  localparam int DG_GE1 = 10;
  // control register bit positions
  localparam int CT_STOP = 0;
  localparam int CT_CLR1 = 9;
  // values after reset
  localparam logic [31:0] RST_UPPER = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_LOWER = 32'h0000_0000;
  localparam logic [31:0] RST_CMP1 = 32'h0000_0000;
  // link timing in link clock cycles
  localparam logic [7:0] LINK_HALF_CYC = 8'h04;
  localparam logic [7:0] LINK_PAUSE_CYC = 8'h40;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {LNK_IDLE, LNK_SHIFT, LNK_PAUSE} sps_link_state_t;
endpackage

// >>> hw/sps_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sps_link_if #(parameter int POS_W = sps_pkg::POS_W);
  logic poll_en;
  logic [POS_W-1:0] pos_word;
  logic pos_toggle;
  logic link_fault;
  modport link (input poll_en, output pos_word, output pos_toggle, output link_fault);
  modport core (output poll_en, input pos_word, input pos_toggle, input link_fault);
endinterface
`default_nettype wire

// >>> hw/sps_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset of the receiving side
  input wire logic clk,
  input wire logic rst_b,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } sps_sync_t;
  sps_sync_t s;
  sps_sync_t next_s;
  // two stages, first read only by second
  always_comb begin
    next_s.meta = d;
    next_s.sync = s.meta;
    if (!rst_b) begin
      next_s.meta = RST_VAL;
      next_s.sync = RST_VAL;
    end
  end
  always_ff @(posedge clk) begin
    s <= next_s;
  end
  assign q = s.sync;
endmodule // sps_sync
`default_nettype wire

// >>> hw/sps_link.sv
`timescale 1ns/1ps
`default_nettype none
module sps_link #(
  parameter int POS_W = sps_pkg::POS_W
) (
  // link clock and core reset
  input wire logic link_clk,
  input wire logic rst_b,
  // encoder pins
  input wire logic enc_data,
  output logic enc_clk,
  // core side
  sps_link_if.link lnk
);
  typedef struct packed {
    sps_pkg::sps_link_state_t st;
    logic [7:0] cnt;
    logic [5:0] nbit;
    logic clk_o;
    logic [POS_W-1:0] shreg;
    logic [POS_W-1:0] word;
    logic toggle;
    logic fault;
  } sps_lnk_t;
  sps_lnk_t s;
  sps_lnk_t next_s;
  logic lrst_b;
  logic [1:0] in_q;
  logic poll;
  logic dat;
  // reset and pins into the link domain
  sps_sync #(.WIDTH(1)) u_rst (
    .clk(link_clk), .rst_b(1'b1), .d(rst_b), .q(lrst_b)
  );
  sps_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_in (
    .clk(link_clk), .rst_b(lrst_b), .d({lnk.poll_en, enc_data}), .q(in_q)
  );
  assign poll = in_q[1];
  assign dat = in_q[0];
  // frame sequencer: clock out, shift in, pause
  always_comb begin
    next_s = s;
    case (s.st)
      sps_pkg::LNK_IDLE: begin
        next_s.clk_o = 1'b1;
        next_s.cnt = '0;
        if (poll) begin // [R7]
          next_s.fault = !dat; // idle line low: open circuit [R3]
          if (dat) begin
            next_s.st = sps_pkg::LNK_SHIFT;
            next_s.clk_o = 1'b0;
            next_s.nbit = '0;
          end
        end
      end
      sps_pkg::LNK_SHIFT: begin
        if (s.cnt == sps_pkg::LINK_HALF_CYC - 8'h01) begin
          next_s.cnt = '0;
          next_s.clk_o = !s.clk_o;
          if (!s.clk_o) begin
            if (s.nbit != 6'h00) begin
              next_s.shreg = {s.shreg[POS_W-2:0], dat};
            end
            if (s.nbit == 6'(POS_W)) begin
              next_s.st = sps_pkg::LNK_PAUSE;
              next_s.word = {s.shreg[POS_W-2:0], dat};
              next_s.toggle = !s.toggle; // new position event [R13]
            end else begin
              next_s.nbit = 6'(s.nbit + 6'h01);
            end
          end
        end else begin
          next_s.cnt = 8'(s.cnt + 8'h01);
        end
      end
      sps_pkg::LNK_PAUSE: begin
        next_s.clk_o = 1'b1;
        if (s.cnt == sps_pkg::LINK_PAUSE_CYC - 8'h01) begin
          next_s.st = sps_pkg::LNK_IDLE;
          next_s.cnt = '0;
        end else begin
          next_s.cnt = 8'(s.cnt + 8'h01);
        end
      end
      default: begin
        next_s.st = sps_pkg::LNK_IDLE;
      end
    endcase
    if (!lrst_b) begin
      next_s = '0;
      next_s.clk_o = 1'b1;
    end
  end
  always_ff @(posedge link_clk) begin
    s <= next_s;
  end
  // outputs, word stands still between toggles
  assign enc_clk = s.clk_o;
  assign lnk.pos_word = s.word;
  assign lnk.pos_toggle = s.toggle;
  assign lnk.link_fault = s.fault;
endmodule // sps_link
`default_nettype wire

// >>> tb/sps_status_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sps_status_chk #(
  parameter int ADDR_W = 10,
  parameter logic [7:0] CHANNELS = 8'h01
) (
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic enc_clk,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  // read address taken, and whether it hits the status word
  logic ar_hs;
  logic diag_rd;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign diag_rd = ar_hs && s_axi_araddr == {sps_pkg::IDX_DIAG, 2'b00};

  chan_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ar_hs && s_axi_araddr == {sps_pkg::IDX_CHAN, 2'b00}
    |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, CHANNELS}) else $error("channel count wrong");
  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    diag_rd |=> s_axi_rdata[6:5] == 2'b00 && s_axi_rdata[31:11] == 21'h00_0000)
    else $error("reserved status bits set");
  fault_suspends_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    diag_rd |=> !s_axi_rdata[4] || s_axi_rdata[7]) else $error("fault without suspend");
  match_implies_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    diag_rd |=> !s_axi_rdata[8] || s_axi_rdata[10])
    else $error("match without ge");
  unmapped_err_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ar_hs && s_axi_araddr[ADDR_W-1:2] > sps_pkg::IDX_POS
    |=> s_axi_rresp == sps_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  read_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  write_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  enc_half_a: assert property (@(posedge link_clk) disable iff (!rst_b)
    $fell(enc_clk) |-> !enc_clk [*4] ##1 enc_clk) else $error("encoder clock low half wrong");
endmodule // sps_status_chk
bind sps_status sps_status_chk #(.ADDR_W(ADDR_W), .CHANNELS(CHANNELS)) u_chk (.ref_clk, .rst_b,
  .link_clk, .enc_clk, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
`default_nettype wire

// >>> tb/sps_enc_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_enc_model #(
  parameter int POS_W = 25
) (
  // encoder pins
  input wire logic enc_clk,
  output logic enc_data,
  // scenario controls
  input wire logic broken,
  input wire logic [POS_W-1:0] pos
);
  logic [POS_W-1:0] sh = '0;
  int cnt = 0;
  logic busy = 1'b0;
  logic dq = 1'b1;
  // first falling edge of a frame freezes the position
  always @(negedge enc_clk) begin
    if (!busy) begin
      sh = pos;
      cnt = POS_W;
      busy = 1'b1;
    end
  end
  // one bit per rising edge, msb first, then low until the monoflop expires
  always @(posedge enc_clk) begin
    if (busy && cnt > 0) begin
      dq = sh[POS_W-1];
      sh = sh << 1;
      cnt = cnt - 1;
    end else if (busy) begin
      dq = 1'b0;
      busy = 1'b0;
      #300 dq = 1'b1;
    end
  end
  // an open cable reads low
  assign enc_data = broken ? 1'b0 : dq;
endmodule // sps_enc_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] P = 32'h0100_0064;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic broken = 1'b0;
  logic enc_data, enc_clk;
  logic [3:0] sts = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int error_cnt = 0;
  int compares = 0;

  // clocks, link clock offset in phase
  always #12.5 ref_clk = ~ref_clk;
  initial begin
    #2.3;
    forever #6 link_clk = ~link_clk;
  end

  sps_status DUT (.ref_clk, .rst_b, .link_clk, .enc_data, .enc_clk,
    .encoder_status_input(sts), .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  sps_enc_model u_enc (.enc_clk, .enc_data, .broken, .pos(P[24:0]));

  task summarize;
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one write, address and data offered together
  task wr(input logic [7:0] idx, input logic [31:0] d);
    logic a_done, w_done;
    a_done = 1'b0;
    w_done = 1'b0;
    @(posedge ref_clk); // ready lines drop for one edge between calls
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a_done && w_done)) begin
      @(posedge ref_clk);
      if (!a_done && s_axi_awready === 1'b1) begin
        a_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge ref_clk);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, sps_pkg::RESP_OKAY});
    s_axi_bready <= 1'b0;
  endtask

  // one read, returns data and response
  task rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk); // ready lines drop for one edge between calls
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task rchk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(nm, d, exp);
  endtask

  // two frame starts after a long high clock: a whole frame ran on the new settings
  task wait_frame;
    int hi;
    repeat (2) begin
      hi = 0;
      while (hi < 20) begin
        @(posedge ref_clk);
        hi = (enc_clk === 1'b1) ? hi + 1 : 0;
      end
      while (enc_clk !== 1'b0) @(posedge ref_clk);
    end
    @(posedge ref_clk);
  endtask

  // encoder clock must stay high once the running frame is over
  task quiet;
    logic lo;
    lo = 1'b0;
    repeat (200) @(posedge ref_clk);
    repeat (300) begin
      @(posedge ref_clk);
      if (enc_clk !== 1'b1) lo = 1'b1;
    end
    chk("enc_clk idle", {31'h0, lo}, 32'h0000_0000);
  endtask

  task t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rchk("chan", sps_pkg::IDX_CHAN, 32'h0000_0001);
    rchk("upper", sps_pkg::IDX_UPPER, sps_pkg::RST_UPPER);
    rchk("lower", sps_pkg::IDX_LOWER, sps_pkg::RST_LOWER);
    rchk("cmp1", sps_pkg::IDX_CMP1, sps_pkg::RST_CMP1);
    wr(sps_pkg::IDX_CHAN, 32'h0000_00FF);
    rchk("chan ro", sps_pkg::IDX_CHAN, 32'h0000_0001);
    rd(8'h77, d, r);
    chk("unmapped resp", {30'h0, r}, {30'h0, sps_pkg::RESP_SLVERR});
    wait_frame;
    rchk("pos", sps_pkg::IDX_POS, P);
    rchk("diag idle", sps_pkg::IDX_DIAG, 32'h0000_0400);
  endtask

  // upper, lower, compare, expected status word
  task t_cmp;
    logic [31:0] up [4] = '{P, P - 1, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
    logic [31:0] lo [4] = '{P, 32'h0000_0000, P + 1, P};
    logic [31:0] cm [4] = '{P, P + 1, 32'h0000_0000, P + 1};
    logic [31:0] ex [4] = '{32'h0000_0700, 32'h0000_0204, 32'h0000_0408, 32'h0000_0000};
    for (int i = 0; i < 4; i++) begin
      wr(sps_pkg::IDX_LOWER, 32'h0000_0000);
      wr(sps_pkg::IDX_UPPER, up[i]);
      wr(sps_pkg::IDX_LOWER, lo[i]);
      wr(sps_pkg::IDX_CMP1, cm[i]);
      wait_frame;
      rchk("diag cmp", sps_pkg::IDX_DIAG, ex[i]);
      if (i == 1) begin
        wr(sps_pkg::IDX_CTRL, 32'h0000_0200);
        rchk("diag clr", sps_pkg::IDX_DIAG, 32'h0000_0004);
      end
    end
  endtask

  task t_suspend;
    wr(sps_pkg::IDX_CTRL, 32'h0000_0001);
    rchk("diag stop", sps_pkg::IDX_DIAG, 32'h0000_0080);
    quiet;
    wr(sps_pkg::IDX_CTRL, 32'h0000_0000);
    wait_frame;
    rchk("diag run", sps_pkg::IDX_DIAG, 32'h0000_0000);
    wr(sps_pkg::IDX_UPPER, 32'h0000_0010);
    quiet;
    rchk("diag param", sps_pkg::IDX_DIAG, 32'h0000_0094);
    wr(sps_pkg::IDX_UPPER, 32'hFFFF_FFFF);
    wait_frame;
    rchk("diag ok", sps_pkg::IDX_DIAG, 32'h0000_0000);
  endtask

  // status pins, enable mask, expected group bit
  task t_group;
    logic [3:0] pin [4] = '{4'h4, 4'h4, 4'h4, 4'h8};
    logic [3:0] en [4] = '{4'h0, 4'h4, 4'hB, 4'hB};
    logic gx [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      sts <= pin[i];
      wr(sps_pkg::IDX_STS_EN, {28'h000_0000, en[i]});
      repeat (6) @(posedge ref_clk);
      rchk("diag group", sps_pkg::IDX_DIAG, {31'h0, gx[i]});
    end
    sts <= 4'h0;
  endtask

  task t_fault;
    logic [31:0] d;
    logic [1:0] r;
    broken <= 1'b1;
    repeat (400) @(posedge ref_clk);
    rd(sps_pkg::IDX_DIAG, d, r);
    chk("link fault", {31'h0, d[1]}, 32'h0000_0001);
    broken <= 1'b0;
    wait_frame;
    wait_frame;
    rchk("diag link ok", sps_pkg::IDX_DIAG, 32'h0000_0000);
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_cmp;
    t_suspend;
    t_group;
    t_fault;
    summarize;
  end

  // watchdog well beyond the longest expected run
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    summarize;
  end
endmodule // tb
`default_nettype wire
